// ===== rtl/usb_ctrl_pkg.sv
package usb_ctrl_pkg;
    // wishbone register byte offsets
    localparam logic [7:0] control_offset = 8'h00;
    localparam logic [7:0] config_offset = 8'h04;
    localparam logic [7:0] status_offset = 8'h08;
    localparam logic [7:0] bdt_ptr_offset = 8'h0c;
    // control register field positions
    localparam int susp_pos = 1;
    localparam int resume_pos = 2;
    localparam int enable_pos = 3;
    localparam int packet_disable_flag_pos = 4;
    localparam int se0_pos = 5;
    localparam int ptr_rst_pos = 6;
    // config register field positions
    localparam int ppb_pos = 0;
    localparam int fs_pos = 2;
    localparam int pullup_pos = 4;
    // values after reset, the ppb none code and block sizes
    localparam logic [7:0] control_reset = 8'h00;
    localparam logic [7:0] config_reset = 8'h00;
    localparam logic [1:0] ppb_none = 2'h0;
    localparam int endpoint_count = 8;
    localparam int register_count = 14;
    localparam int ram_dual_bytes = 496;
    localparam int ram_access_bytes = 16;

    typedef struct packed {
        logic pullup_en;
        logic full_speed;
        logic idle_drive;
        logic resume_drive;
        logic sie_clk_en;
        logic sie_active;
    } phy_ctrl_t;

    typedef struct packed {
        logic [7:0] adr;
        logic [31:0] dat;
        logic we;
        logic [3:0] sel;
    } wb_req_t;
endpackage

// ===== rtl/usb_module_control.sv
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module usb_module_control
    import usb_ctrl_pkg::*;
#(
    parameter int endpoints = endpoint_count
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    // bus line state from transceiver pins
    input wire logic dp_i,
    input wire logic dm_i,
    // serial engine events
    input wire logic setup_token_i,
    input wire logic configured_i,
    // engine side of pointer table
    input wire logic [endpoints-1:0] ptr_toggle_i,
    output logic [endpoints-1:0] pingpong_pointer_bit_o,
    // transceiver control
    output phy_ctrl_t phy_o
);
    logic [1:0] dp_sync_r;
    logic [1:0] dm_sync_r;
    logic single_ended_zero_flag_r;
    logic module_enable_bit_r;
    logic suspend_bit_r;
    logic resume_bit_r;
    logic packet_disable_flag_r;
    logic pingpong_pointer_reset_r;
    logic [1:0] ppb_mode_r;
    logic full_speed_select_bit_r;
    logic pullup_enable_bit_r;
    logic [endpoints-1:0] ptr_r;
    logic [endpoints-1:0] ptr_nxt;
    logic ack_r;
    logic err_r;
    logic [31:0] rdata_r;

    wire logic req = cyc_i && stb_i && !ack_r && !err_r;
    wire logic hit_ctrl = adr_i == control_offset;
    wire logic hit_cfg = adr_i == config_offset;
    wire logic hit_stat = adr_i == status_offset;
    wire logic hit_ptr = adr_i == bdt_ptr_offset;
    wire logic mapped = hit_ctrl || hit_cfg || hit_stat || hit_ptr;
    // buffer ram lives outside this block, shared with the engine
    localparam int ram_bytes = ram_dual_bytes + ram_access_bytes;
    wire logic wr_ctrl = req && we_i && hit_ctrl && sel_i[0];
    wire logic wr_cfg = req && we_i && hit_cfg && sel_i[0];
    wire logic enable_rise = wr_ctrl && dat_i[enable_pos] && !module_enable_bit_r;
    wire logic pingpong_used = ppb_mode_r != ppb_none;
    wire logic hold_even = pingpong_pointer_reset_r && pingpong_used;

    wire logic [7:0] ctrl_view = {1'b0, pingpong_pointer_reset_r, single_ended_zero_flag_r,
        packet_disable_flag_r, module_enable_bit_r, resume_bit_r, suspend_bit_r, 1'b0};
    wire logic [7:0] cfg_view = {3'h0, pullup_enable_bit_r, 1'b0,
        full_speed_select_bit_r, ppb_mode_r};
    wire logic [31:0] read_mux =
        hit_ctrl ? {24'h0, ctrl_view} :
        hit_cfg ? {24'h0, cfg_view} :
        hit_ptr ? 32'(ptr_r) :
        hit_stat ? {30'h0, configured_i, single_ended_zero_flag_r} : 32'h0;

    // pins are asynchronous to clk_i
    always_ff @(posedge clk_i) begin
        dp_sync_r <= {dp_sync_r[0], dp_i};
        dm_sync_r <= {dm_sync_r[0], dm_i};
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            single_ended_zero_flag_r <= 1'b0;
        end else begin
            single_ended_zero_flag_r <= !dp_sync_r[1] && !dm_sync_r[1];
        end
    end

    // control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            module_enable_bit_r <= control_reset[enable_pos];
            suspend_bit_r <= control_reset[susp_pos];
            resume_bit_r <= control_reset[resume_pos];
            pingpong_pointer_reset_r <= control_reset[ptr_rst_pos];
        end else if (wr_ctrl) begin
            module_enable_bit_r <= dat_i[enable_pos];
            suspend_bit_r <= dat_i[susp_pos];
            // resume is held by firmware for its full duration
            resume_bit_r <= dat_i[resume_pos];
            pingpong_pointer_reset_r <= dat_i[ptr_rst_pos];
        end
    end

    // setup token while module enable bit is set wins over a firmware clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            packet_disable_flag_r <= control_reset[packet_disable_flag_pos];
        end else if (setup_token_i && module_enable_bit_r) begin
            packet_disable_flag_r <= 1'b1;
        end else if (wr_ctrl && !dat_i[packet_disable_flag_pos]) begin
            packet_disable_flag_r <= 1'b0;
        end
    end

    // configuration register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ppb_mode_r <= config_reset[ppb_pos +: 2];
            full_speed_select_bit_r <= config_reset[fs_pos];
            pullup_enable_bit_r <= config_reset[pullup_pos];
        end else if (wr_cfg) begin
            ppb_mode_r <= dat_i[ppb_pos +: 2];
            full_speed_select_bit_r <= dat_i[fs_pos];
            pullup_enable_bit_r <= dat_i[pullup_pos];
        end
    end

    // pointer table: engine toggles, enable forces even, reset bit forces even only when ppb mode is not none
    always_comb begin
        ptr_nxt = ptr_r ^ ptr_toggle_i;
        if (enable_rise) begin
            ptr_nxt = '0;
        end else if (hold_even) begin
            ptr_nxt = '0;
        end else if (!module_enable_bit_r || suspend_bit_r || packet_disable_flag_r) begin
            ptr_nxt = ptr_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ptr_r <= '0;
        end else begin
            ptr_r <= ptr_nxt;
        end
    end

    // wishbone answer one cycle after the request, dropped next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            err_r <= 1'b0;
            rdata_r <= 32'h0;
        end else begin
            ack_r <= req && mapped;
            err_r <= req && !mapped;
            if (req && !we_i) begin
                rdata_r <= read_mux;
            end
        end
    end

    assign ack_o = ack_r;
    assign err_o = err_r;
    assign dat_o = rdata_r;
    assign pingpong_pointer_bit_o = ptr_r;

    // attach follows enable; pull-ups also need config and pull-up bit
    assign phy_o.pullup_en = pullup_enable_bit_r && module_enable_bit_r && configured_i;
    assign phy_o.full_speed = full_speed_select_bit_r;
    assign phy_o.idle_drive = suspend_bit_r;
    assign phy_o.resume_drive = resume_bit_r && module_enable_bit_r;
    assign phy_o.sie_clk_en = module_enable_bit_r && !suspend_bit_r;
    assign phy_o.sie_active = module_enable_bit_r && !suspend_bit_r
        && !packet_disable_flag_r;
endmodule // usb_module_control
`default_nettype wire

// ===== dv/usb_module_control_props.sv
`timescale 1ns/1ps
`default_nettype none
module usb_module_control_props
    import usb_ctrl_pkg::*;
#(
    parameter int endpoints = endpoint_count
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic err_o,
    input wire logic setup_token_i,
    input wire logic configured_i,
    input wire logic [endpoints-1:0] pingpong_pointer_bit_o,
    input wire phy_ctrl_t phy_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic req = cyc_i && stb_i && !ack_o && !err_o;
    wire logic mapped = adr_i[7:4] == 4'h0 && adr_i[1:0] == 2'h0;
    property p_ack_pulse; ack_o |=> !ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_mapped; req && mapped |=> ack_o && !err_o; endproperty
    a_mapped: assert property (p_mapped) else $error("no ack");
    property p_unmapped; req && !mapped |=> err_o && !ack_o; endproperty
    a_unmapped: assert property (p_unmapped) else $error("no err");
    property p_upper; ack_o |-> dat_o[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper bits set");
    property p_pullup; phy_o.pullup_en |-> configured_i; endproperty
    a_pullup: assert property (p_pullup) else $error("pullup early");
    property p_ptr_clear;
        $rose(phy_o.sie_clk_en) && !$past(phy_o.idle_drive) |->
            ##[0:1] pingpong_pointer_bit_o == '0;
    endproperty
    a_ptr_clear: assert property (p_ptr_clear) else $error("ptr kept");
    property p_setup;
        setup_token_i && phy_o.sie_active |=> ##1 $stable(pingpong_pointer_bit_o)[*2];
    endproperty
    a_setup: assert property (p_setup) else $error("ptr moved");
    property p_susp;
        phy_o.idle_drive && $past(phy_o.idle_drive) |->
            !phy_o.sie_clk_en && $stable(pingpong_pointer_bit_o);
    endproperty
    a_susp: assert property (p_susp) else $error("engine runs");
endmodule // usb_module_control_props
bind usb_module_control usb_module_control_props #(.endpoints(endpoints)) props (.*);
`default_nettype wire

// ===== dv/usb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
    input wire logic clk_i,
    input wire logic se0_i,
    output logic dp_o,
    output logic dm_o
);
    // idle is a full-speed j state, bus reset pulls both lines low
    always_ff @(posedge clk_i) begin
        dp_o <= !se0_i;
        dm_o <= 1'b0;
    end
endmodule // usb_host_model
`default_nettype wire

// ===== dv/usb_module_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module usb_module_control_tb;
    import usb_ctrl_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, se0 = 0, fs;
    logic setup_token_i = 0, configured_i = 0, ack_o, err_o, dp_i, dm_i;
    logic [7:0] adr_i = 0, ptr_toggle_i = 0, pingpong_pointer_bit_o, ep = 0, r;
    logic [3:0] sel_i = 4'hf;
    logic [31:0] dat_i = 0, dat_o;
    logic [33:0] q[$], n;
    phy_ctrl_t phy_o;
    int n_mismatch = 0, samples_checked = 0, cyc_n = 0;
    always #12.5 clk_i = !clk_i;
    usb_host_model host (.clk_i(clk_i), .se0_i(se0), .dp_o(dp_i), .dm_o(dm_i));
    usb_module_control dut (.*);
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("FAIL %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic print_verdict();
        $display("mismatches %0d checked %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // for a read, d is the expected data
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, input logic e = 0);
        q.push_back({!w, e, d});
        cyc_i <= 1;
        stb_i <= 1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        @(posedge clk_i);
        while (!(ack_o || err_o)) @(posedge clk_i);
        cyc_i <= 0;
        stb_i <= 0;
        @(posedge clk_i);
    endtask
    task automatic tg(input logic [7:0] v, input logic f);
        ptr_toggle_i <= v;
        if (f) ep = ep ^ v;
        @(posedge clk_i);
        ptr_toggle_i <= 0;
        @(posedge clk_i);
    endtask
    always @(posedge clk_i) begin
        if (ack_o || err_o) begin
            n = q.pop_front();
            chk("err", {31'h0, n[32]}, {31'h0, err_o});
            if (n[33]) chk("rdata", n[31:0], dat_o);
        end
    end
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 4000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    initial begin
        void'($urandom(32'h1390ce13));
        {fs, r} = 9'($urandom);
        repeat (10) @(posedge clk_i);
        rst_i <= 0;
        chk("phy", 0, {26'h0, phy_o});
        bus(control_offset, 0, 0);
        bus(8'h10, 0, 0, 1);
        configured_i <= 1;
        bus(config_offset, 1, {27'h0, 2'h2, fs, 2'h1});
        bus(control_offset, 1, 8'h08);
        chk("phy", {26'h0, 1'b1, fs, 4'h3}, {26'h0, phy_o});
        tg(r, 1);
        bus(bdt_ptr_offset, 0, {24'h0, ep});
        bus(control_offset, 1, 8'h48);
        tg(8'hff, 0);
        ep = 0;
        bus(bdt_ptr_offset, 0, 0);
        bus(control_offset, 1, 8'h08);
        bus(config_offset, 1, {27'h0, 2'h2, fs, 2'h0});
        tg(r, 1);
        bus(control_offset, 1, 8'h48);
        bus(bdt_ptr_offset, 0, {24'h0, ep});
        bus(control_offset, 1, 8'h08);
        setup_token_i <= 1;
        @(posedge clk_i);
        setup_token_i <= 0;
        tg(~r, 0);
        bus(control_offset, 0, 8'h18);
        bus(bdt_ptr_offset, 0, {24'h0, ep});
        bus(control_offset, 1, 8'h08);
        bus(control_offset, 1, 8'h18);
        bus(control_offset, 0, 8'h08);
        se0 <= 1;
        repeat (6) @(posedge clk_i);
        bus(control_offset, 0, 8'h28);
        bus(status_offset, 0, 3);
        se0 <= 0;
        repeat (6) @(posedge clk_i);
        bus(control_offset, 0, 8'h08);
        // resume hold shortened, timing is firmware's job
        bus(control_offset, 1, 8'h0c);
        chk("resume", 1, {31'h0, phy_o.resume_drive});
        bus(control_offset, 1, 8'h0a);
        chk("phy", {26'h0, 1'b1, fs, 4'h8}, {26'h0, phy_o});
        tg(~r, 0);
        bus(bdt_ptr_offset, 0, {24'h0, ep});
        bus(control_offset, 1, 0);
        chk("pullup", 0, {31'h0, phy_o.pullup_en});
        bus(control_offset, 1, 8'h08);
        bus(bdt_ptr_offset, 0, 0);
        print_verdict();
    end
endmodule // usb_module_control_tb
`default_nettype wire
